// ===== design/enhanced_op_decoder.v
// Instruction decode and execute core for the enhanced op subset
// Behaviour
// - Branches, calls and returns take two cycles
// - Window access via high pointer stalls once
// - Relative jump by accumulator, two cycles
// - Subroutine jump by accumulator, saves return
// - Literal exit loads literal into accumulator
// - Accumulator copied to prescaler configuration
// - Accumulator copied to selected direction register
// - Standby and watchdog kick update flags
// - Pointer add-immediate selects pointer by n
// - Signed six-bit add, flags untouched
// - Pointer arithmetic wraps modulo 65536
// - Pointer load with modify updates zero
// - Indexed pointer load updates zero
// - Pointer store with modify, flags untouched
// - Indexed pointer store, flags untouched
// - AND immediate, zero flag only
// - ADD immediate sets carry, half, zero
// - AND with file, zero flag only
// - Destination bit picks accumulator or file
// - Absolute jumps carry eleven-bit target
// - Relative jump carries nine-bit offset
// - Pointer modify fields n and m
`timescale 1ns/10ps
`default_nettype none
`include "op_decoder_map.vh"

module enhanced_op_decoder #(
  parameter STACK_DEPTH = 16,
  parameter MEM_WORDS = 256
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg standby,
  output reg sw_reset,
  output reg busy
);

  // ---------------------------------------------------------------
  // State machine and architectural state
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_WAIT = 3'b100;

  // Sequencer: one-hot state and filler cycles still owed
  reg [2:0] state;
  reg [1:0] cyc_left;
  reg [13:0] instr;

  // Programmer-visible core registers
  reg [7:0] acc;
  reg [4:0] status;
  reg [15:0] ptr0;
  reg [15:0] ptr1;
  reg [14:0] pc;
  reg [7:0] cfg;
  reg [7:0] dir [0:`DIR_COUNT-1];

  // Return stack and byte-wide data memory
  reg [14:0] stack [0:STACK_DEPTH-1];
  reg [3:0] sp;
  reg [7:0] mem [0:MEM_WORDS-1];

  // Bus windows: memory address, file operand, counters
  reg [15:0] mem_addr;
  reg [7:0] file_rd;
  reg [7:0] file_wr;
  reg [15:0] events;
  reg [31:0] cycles;

  // Decoder and pointer unit results
  wire [4:0] op_class;
  wire two_cycle;
  wire [15:0] ptr_sel;
  wire [15:0] acc_addr;
  wire [15:0] ptr_new;
  wire is_idx;
  wire is_window_op;

  op_classify u_cls (
    .opcode(instr),
    .op_class(op_class),
    .two_cycle(two_cycle)
  );

  // Op groups; offset ops name their pointer in bit 6
  assign ptr_sel = instr[6] ? ptr1 : ptr0;
  assign is_idx = (op_class == `OP_PTR_LOAD_IDX) ||
    (op_class == `OP_PTR_STORE_IDX) || (op_class == `OP_PTR_ADD);
  assign is_window_op = (op_class == `OP_PTR_LOAD) ||
    (op_class == `OP_PTR_STORE) || (op_class == `OP_PTR_LOAD_IDX) ||
    (op_class == `OP_PTR_STORE_IDX);

  // Low-bit ops use n in bit 2; indexed ops use n in bit 6
  wire [15:0] ptr_mod_in = is_idx ? ptr_sel : (instr[2] ? ptr1 : ptr0);

  ptr_modify u_ptr (
    .ptr_in(ptr_mod_in),
    .offset(instr[5:0]),
    .use_offset(is_idx),
    .mode(instr[1:0]),
    .access_addr(acc_addr),
    .ptr_out(ptr_new)
  );

  // ---------------------------------------------------------------
  // Bus decode helper
  // ---------------------------------------------------------------
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a <= `REG_FILE_WR) && (a[1:0] == 2'b00);
    end
  endfunction

  // Phase decode; a write lands only in the answered access cycle
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire wr_ok = access && pwrite && is_mapped(paddr);

  // Data sums for the arithmetic ops
  wire [8:0] add_sum = {1'b0, acc} + {1'b0, instr[7:0]};
  wire [4:0] half_sum = {1'b0, acc[3:0]} + {1'b0, instr[3:0]};
  wire [7:0] and_lit = acc & instr[7:0];
  wire [7:0] and_file = acc & file_rd;
  wire [7:0] mem_rd = mem[acc_addr[7:0]];
  // Stall follows the chosen pointer's top bit, not the modified address
  wire ptr_stall = ptr_mod_in[15] && is_window_op;

  // Index for the direction register reset loop
  integer i;

  // ---------------------------------------------------------------
  // Bus slave: no wait state, answer in the first access cycle
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      // No wait state: ready answers in the cycle after every setup cycle
      pready <= setup;
      pslverr <= setup && !is_mapped(paddr);
      // Read data is taken in setup and stands through the access
      if (setup && !pwrite) begin
        case (paddr)
          `REG_CTRL: prdata <= {29'h0, state};
          `REG_INSTR: prdata <= {18'h0, instr};
          `REG_ACC: prdata <= {24'h0, acc};
          `REG_STATUS: prdata <= {27'h0, status};
          `REG_PTR0: prdata <= {16'h0, ptr0};
          `REG_PTR1: prdata <= {16'h0, ptr1};
          `REG_PC: prdata <= {17'h0, pc};
          `REG_CFG: prdata <= {24'h0, cfg};
          `REG_DIR: prdata <= {24'h0, dir[mem_addr[2:0]]};
          `REG_MEM_ADDR: prdata <= {16'h0, mem_addr};
          `REG_MEM_RDATA: prdata <= {24'h0, mem[mem_addr[7:0]]};
          `REG_EVENT: prdata <= {events, cycles[15:0]};
          `REG_FILE_RD: prdata <= {24'h0, file_rd};
          `REG_FILE_WR: prdata <= {24'h0, file_wr};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Execute: writing INSTR starts an op; cycles counted in every execute and filler cycle
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cyc_left <= 2'd0;
      instr <= 14'h0000;
      acc <= `ACC_RST;
      status <= `STATUS_RST;
      ptr0 <= `PTR_RST;
      ptr1 <= `PTR_RST;
      pc <= `PC_RST;
      cfg <= `CFG_RST;
      sp <= 4'h0;
      mem_addr <= 16'h0000;
      file_rd <= 8'h00;
      file_wr <= 8'h00;
      events <= 16'h0000;
      cycles <= 32'h00000000;
      standby <= 1'b0;
      sw_reset <= 1'b0;
      busy <= 1'b0;
      for (i = 0; i < `DIR_COUNT; i = i + 1) begin
        dir[i] <= `DIR_RST;
      end
    end else begin
      sw_reset <= 1'b0;
      // Window address and file operand may be written at any time
      if (wr_ok && paddr == `REG_MEM_ADDR) begin
        mem_addr <= pwdata[15:0];
      end
      if (wr_ok && paddr == `REG_FILE_RD) begin
        file_rd <= pwdata[7:0];
      end
      // Core state only while idle, so a running op is never disturbed
      if (wr_ok && paddr == `REG_ACC && state == ST_IDLE) begin
        acc <= pwdata[7:0];
      end
      if (wr_ok && paddr == `REG_PTR0 && state == ST_IDLE) begin
        ptr0 <= pwdata[15:0];
      end
      if (wr_ok && paddr == `REG_PTR1 && state == ST_IDLE) begin
        ptr1 <= pwdata[15:0];
      end
      if (wr_ok && paddr == `REG_MEM_RDATA && state == ST_IDLE) begin
        mem[mem_addr[7:0]] <= pwdata[7:0];
      end
      // Wake request; a standby op in the same cycle still wins
      if (wr_ok && paddr == `REG_CTRL && pwdata[0]) begin
        standby <= 1'b0; // Wake from standby
      end
      case (state)
        ST_IDLE: begin
          // Opcodes are refused while an op runs or in standby
          if (wr_ok && paddr == `REG_INSTR && !standby) begin
            instr <= pwdata[13:0];
            state <= ST_EXEC;
            busy <= 1'b1;
          end
        end
        ST_EXEC: begin
          // Count the cycle and step past the opcode
          cycles <= cycles + 32'h00000001;
          pc <= pc + 15'h0001;
          cyc_left <= two_cycle ? `CYC_TWO - 2'd1 : 2'd0;
          if (ptr_stall) begin
            cyc_left <= `CYC_STALL;
          end
          // Sticky record of op classes run; classes 16 and up fold onto bits 0 to 15
          events[op_class[3:0]] <= 1'b1;
          // Per-class effects; foreign opcodes only use up the cycle
          case (op_class)
            `OP_SW_RESET: sw_reset <= 1'b1;
            `OP_REL_ACC: pc <= pc + 15'h0001 + {7'h00, acc};
            `OP_SUB_ACC: begin
              stack[sp] <= pc + 15'h0001;
              sp <= sp + 4'h1;
              pc <= {pc[14:8], acc};
            end
            `OP_SUB_EXIT, `OP_INT_EXIT: begin
              pc <= stack[sp - 4'h1];
              sp <= sp - 4'h1;
            end
            `OP_LIT_EXIT: begin
              acc <= instr[7:0];
              pc <= stack[sp - 4'h1];
              sp <= sp - 4'h1;
            end
            `OP_REL_JUMP: pc <= pc + 15'h0001 +
              {{6{instr[8]}}, instr[8:0]};
            `OP_SUB_ABS: begin
              stack[sp] <= pc + 15'h0001;
              sp <= sp + 4'h1;
              pc <= {pc[14:11], instr[10:0]};
            end
            `OP_ABS_JUMP: pc <= {pc[14:11], instr[10:0]};
            `OP_CFG_LOAD: cfg <= acc;
            `OP_DIR_LOAD: dir[instr[2:0]] <= acc;
            `OP_STANDBY: begin
              standby <= 1'b1;
              status[`ST_TO] <= 1'b1;
              status[`ST_PD] <= 1'b0;
            end
            `OP_WDT_KICK: begin
              status[`ST_TO] <= 1'b1;
              status[`ST_PD] <= 1'b1;
            end
            `OP_PTR_ADD: begin
              if (instr[6]) ptr1 <= ptr_new;
              else ptr0 <= ptr_new;
            end
            `OP_PTR_LOAD, `OP_PTR_LOAD_IDX: begin
              acc <= mem_rd;
              status[`ST_Z] <= (mem_rd == 8'h00);
              if (!is_idx && instr[2]) ptr1 <= ptr_new;
              else if (!is_idx) ptr0 <= ptr_new;
            end
            `OP_PTR_STORE, `OP_PTR_STORE_IDX: begin
              mem[acc_addr[7:0]] <= acc;
              if (!is_idx && instr[2]) ptr1 <= ptr_new;
              else if (!is_idx) ptr0 <= ptr_new;
            end
            `OP_AND_IMM: begin
              acc <= and_lit;
              status[`ST_Z] <= (and_lit == 8'h00);
            end
            `OP_ADD_IMM: begin
              acc <= add_sum[7:0];
              status[`ST_C] <= add_sum[8];
              status[`ST_DC] <= half_sum[4];
              status[`ST_Z] <= (add_sum[7:0] == 8'h00);
            end
            `OP_AND_FILE: begin
              status[`ST_Z] <= (and_file == 8'h00);
              if (instr[7]) file_wr <= and_file;
              else acc <= and_file;
            end
            default: ; // Idle op and foreign opcodes
          endcase
          // Filler cycle for control transfers and pointer stalls
          if (two_cycle || ptr_stall) begin
            state <= ST_WAIT;
          end else begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        ST_WAIT: begin
          // Idle filler cycle; nothing architectural changes
          cycles <= cycles + 32'h00000001;
          if (cyc_left <= 2'd1) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
          cyc_left <= cyc_left - 2'd1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== design/op_decoder_map.vh
// Operation classes, register offsets, field positions and reset values
`ifndef OP_DECODER_MAP_VH
`define OP_DECODER_MAP_VH

// ---------------------------------------------------------------
// Register offsets (byte addresses on the bus)
// ---------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_INSTR 12'h004
`define REG_ACC 12'h008
`define REG_STATUS 12'h00C
`define REG_PTR0 12'h010
`define REG_PTR1 12'h014
`define REG_PC 12'h018
`define REG_CFG 12'h01C
`define REG_DIR 12'h020
`define REG_MEM_ADDR 12'h024
`define REG_MEM_RDATA 12'h028
`define REG_EVENT 12'h02C
`define REG_FILE_RD 12'h030
`define REG_FILE_WR 12'h034

// ---------------------------------------------------------------
// Status field positions and reset values
// ---------------------------------------------------------------
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_PD 3
`define ST_TO 4
`define STATUS_RST 5'h18
`define ACC_RST 8'h00
`define PTR_RST 16'h0000
`define PC_RST 15'h0000
`define CFG_RST 8'hFF
`define DIR_RST 8'hFF
`define DIR_COUNT 8

// ---------------------------------------------------------------
// Timing counts, in instruction cycles
// ---------------------------------------------------------------
`define CYC_ONE 2'd1
`define CYC_TWO 2'd2
`define CYC_STALL 2'd1

// ---------------------------------------------------------------
// Pointer modify modes (mm field)
// ---------------------------------------------------------------
`define MM_PRE_INC 2'b00
`define MM_PRE_DEC 2'b01
`define MM_POST_INC 2'b10
`define MM_POST_DEC 2'b11

// ---------------------------------------------------------------
// Operation classes from the decoder
// ---------------------------------------------------------------
`define OP_IDLE 5'd0
`define OP_SW_RESET 5'd1
`define OP_REL_ACC 5'd2
`define OP_SUB_ACC 5'd3
`define OP_SUB_EXIT 5'd4
`define OP_INT_EXIT 5'd5
`define OP_LIT_EXIT 5'd6
`define OP_REL_JUMP 5'd7
`define OP_SUB_ABS 5'd8
`define OP_ABS_JUMP 5'd9
`define OP_CFG_LOAD 5'd10
`define OP_DIR_LOAD 5'd11
`define OP_STANDBY 5'd12
`define OP_WDT_KICK 5'd13
`define OP_PTR_ADD 5'd14
`define OP_PTR_LOAD 5'd15
`define OP_PTR_LOAD_IDX 5'd16
`define OP_PTR_STORE 5'd17
`define OP_PTR_STORE_IDX 5'd18
`define OP_AND_IMM 5'd19
`define OP_ADD_IMM 5'd20
`define OP_AND_FILE 5'd21
`define OP_OTHER 5'd31

`endif

// ===== design/op_classify.v
// Combinational opcode classifier for the decoder
`timescale 1ns/10ps
`default_nettype none
`include "op_decoder_map.vh"

module op_classify (
  input wire [13:0] opcode,
  output reg [4:0] op_class,
  output reg two_cycle
);

  // ---------------------------------------------------------------
  // Pattern match; exact codes first, then fields
  // ---------------------------------------------------------------
  always @* begin
    op_class = `OP_OTHER;
    casez (opcode)
      14'h0000: op_class = `OP_IDLE;
      14'h0001: op_class = `OP_SW_RESET;
      14'h000B: op_class = `OP_REL_ACC;
      14'h000A: op_class = `OP_SUB_ACC;
      14'h0008: op_class = `OP_SUB_EXIT;
      14'h0009: op_class = `OP_INT_EXIT;
      14'h0062: op_class = `OP_CFG_LOAD;
      14'h0063: op_class = `OP_STANDBY;
      14'h0064: op_class = `OP_WDT_KICK;
      14'b00_0000_0110_0???: op_class = `OP_DIR_LOAD;
      14'b00_0000_0001_0???: op_class = `OP_PTR_LOAD;
      14'b00_0000_0001_1???: op_class = `OP_PTR_STORE;
      14'b11_0100_????_????: op_class = `OP_LIT_EXIT;
      14'b11_001?_????_????: op_class = `OP_REL_JUMP;
      14'b10_0???_????_????: op_class = `OP_SUB_ABS;
      14'b10_1???_????_????: op_class = `OP_ABS_JUMP;
      14'b11_0001_0???_????: op_class = `OP_PTR_ADD;
      14'b11_1111_0???_????: op_class = `OP_PTR_LOAD_IDX;
      14'b11_1111_1???_????: op_class = `OP_PTR_STORE_IDX;
      14'b11_1001_????_????: op_class = `OP_AND_IMM;
      14'b11_1110_????_????: op_class = `OP_ADD_IMM;
      14'b00_0101_????_????: op_class = `OP_AND_FILE;
      default: op_class = `OP_OTHER;
    endcase
  end

  // ---------------------------------------------------------------
  // Every jump, call and return costs a second, idle cycle
  // ---------------------------------------------------------------
  always @* begin
    case (op_class)
      `OP_REL_ACC, `OP_SUB_ACC, `OP_SUB_EXIT, `OP_INT_EXIT,
      `OP_LIT_EXIT, `OP_REL_JUMP, `OP_SUB_ABS,
      `OP_ABS_JUMP: two_cycle = 1'b1;
      default: two_cycle = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ===== design/ptr_modify.v
// Pointer arithmetic: signed add, pre/post modify, indexed address
`timescale 1ns/10ps
`default_nettype none
`include "op_decoder_map.vh"

module ptr_modify (
  input wire [15:0] ptr_in,
  input wire [5:0] offset,
  input wire use_offset,
  input wire [1:0] mode,
  output reg [15:0] access_addr,
  output reg [15:0] ptr_out
);

  reg [15:0] ext;
  reg [15:0] plus_one;
  reg [15:0] minus_one;

  // ---------------------------------------------------------------
  // Sums are held at 16 bits, so overflow wraps modulo 65536
  // ---------------------------------------------------------------
  always @* begin
    ext = {{10{offset[5]}}, offset};
    plus_one = ptr_in + 16'h0001;
    minus_one = ptr_in - 16'h0001;
    access_addr = ptr_in;
    ptr_out = ptr_in;
    if (use_offset) begin
      access_addr = ptr_in + ext;
      ptr_out = ptr_in + ext;
    end else begin
      case (mode)
        `MM_PRE_INC: begin
          access_addr = plus_one;
          ptr_out = plus_one;
        end
        `MM_PRE_DEC: begin
          access_addr = minus_one;
          ptr_out = minus_one;
        end
        `MM_POST_INC: begin
          ptr_out = plus_one;
        end
        default: begin
          ptr_out = minus_one;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== testbench/enhanced_op_decoder_asserts.sv
// Port-level assertions for the enhanced op decoder
`timescale 1ns/10ps
`default_nettype none
`include "op_decoder_map.vh"
module enhanced_op_decoder_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic standby,
  input wire logic sw_reset,
  input wire logic busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted opcode write; refused ones must not start anything
  wire logic go = psel && penable && pready && pwrite &&
    paddr == `REG_INSTR && !busy && !standby;
  wire logic wake = psel && penable && pready && pwrite &&
    paddr == `REG_CTRL && pwdata[0];
  wire logic [13:0] op = pwdata[13:0];
  resp_timing_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  resp_pulse_a: assert property (pready |=> !pready)
    else $error("answer held too long");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("error without answer");
  op_start_a: assert property (go |=> busy)
    else $error("accepted opcode did not start");
  busy_bound_a: assert property ($rose(busy) |-> ##[1:3] !busy)
    else $error("operation too long");
  idle_len_a: assert property (go && op == 14'h0000 |=> busy ##1 !busy)
    else $error("idle op not one cycle");
  acc_jump_len_a: assert property (go && op == 14'h000B |=> busy[*2] ##1 !busy)
    else $error("jump by acc not two cycles");
  acc_call_len_a: assert property (go && op == 14'h000A |=> busy[*2] ##1 !busy)
    else $error("call by acc not two cycles");
  lit_exit_len_a: assert property (go && op[13:8] == 6'h34 |=> busy[*2] ##1 !busy)
    else $error("literal exit not two cycles");
  and_imm_len_a: assert property (go && op[13:8] == 6'h39 |=> busy ##1 !busy)
    else $error("and immediate not one cycle");
  reset_pulse_a: assert property (sw_reset |=> !sw_reset)
    else $error("reset request held");
  sleep_hold_a: assert property (standby && !wake |=> standby)
    else $error("standby left without wake");
  sleep_cause_a: assert property ($rose(standby) |-> $past(busy))
    else $error("standby without operation");
endmodule
`default_nettype wire

// ===== testbench/enhanced_op_decoder_tb.sv
// Self-checking bench for the enhanced op decoder
`timescale 1ns/10ps
`default_nettype none
`include "op_decoder_map.vh"
module enhanced_op_decoder_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rv;
  logic se;
  logic sr = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, standby, sw_reset, busy;
  int err_total = 0;
  int n_checks = 0;
  int nc;
  // 100 MHz clock
  always #5 pclk = ~pclk;
  // Latch the one-cycle reset request so a late look still sees it
  always @(posedge pclk) if (sw_reset === 1'b1) sr <= 1'b1;
  enhanced_op_decoder i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .standby, .sw_reset,
    .busy);
  // Comparison and verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // APB transfer; an idle edge first so no signal is driven twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      stop_test();
    end
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rv, e);
  endtask
  // Issue an opcode and count the cycles busy stays high
  task automatic exec(input logic [13:0] op);
    int i;
    wr(`REG_INSTR, {18'h0, op});
    nc = 0;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (busy !== 1'b1) break;
      nc++;
    end
    if (i == 20) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic t_reset();
    rd(`REG_STATUS, 32'h18);
    apb(1'b0, 12'h0FC, 32'h0);
    check(se, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_arith();
    wr(`REG_ACC, 32'h0F);
    exec(14'h3E01);
    rd(`REG_ACC, 32'h10);
    rd(`REG_STATUS, 32'h1A);
    exec(14'h3EF0);
    rd(`REG_STATUS, 32'h1D);
    wr(`REG_ACC, 32'hF3);
    exec(14'h39FE);
    rd(`REG_ACC, 32'hF2);
    rd(`REG_STATUS, 32'h19);
    $display("arith test done");
  endtask
  task automatic t_file();
    wr(`REG_FILE_RD, 32'h3C);
    exec(14'h0592);
    rd(`REG_FILE_WR, 32'h30);
    rd(`REG_ACC, 32'hF2);
    exec(14'h0512);
    rd(`REG_ACC, 32'h30);
    wr(`REG_FILE_RD, 32'h0F);
    exec(14'h0512);
    rd(`REG_STATUS, 32'h1D);
    $display("file test done");
  endtask
  task automatic t_ptr();
    wr(`REG_PTR0, 32'h0);
    exec(14'h313F);
    rd(`REG_PTR0, 32'hFFFF);
    rd(`REG_STATUS, 32'h1D);
    wr(`REG_PTR1, 32'hFFFF);
    exec(14'h3141);
    rd(`REG_PTR1, 32'h0);
    rd(`REG_PTR0, 32'hFFFF);
    wr(`REG_PTR0, 32'h20);
    wr(`REG_ACC, 32'h5A);
    exec(14'h001A);
    check(nc, 1);
    wr(`REG_MEM_ADDR, 32'h20);
    rd(`REG_MEM_RDATA, 32'h5A);
    rd(`REG_PTR0, 32'h21);
    rd(`REG_STATUS, 32'h1D);
    wr(`REG_ACC, 32'h0);
    exec(14'h0011);
    rd(`REG_ACC, 32'h5A);
    rd(`REG_PTR0, 32'h20);
    rd(`REG_STATUS, 32'h19);
    wr(`REG_PTR1, 32'h1E);
    wr(`REG_ACC, 32'h0);
    exec(14'h3F42);
    rd(`REG_ACC, 32'h5A);
    wr(`REG_MEM_ADDR, 32'h21);
    wr(`REG_MEM_RDATA, 32'hAA);
    exec(14'h3FC3);
    rd(`REG_MEM_RDATA, 32'h5A);
    rd(`REG_STATUS, 32'h19);
    // High pointer bit reaches the window and costs a stall cycle
    wr(`REG_PTR0, 32'h8020);
    exec(14'h0010);
    check(nc, 2);
    // Top bit clear before the modify: no stall, even if it carries over
    wr(`REG_PTR0, 32'h7FFF);
    exec(14'h0018);
    check(nc, 1);
    $display("pointer test done");
  endtask
  task automatic t_ctl();
    logic [13:0] ops [12] = '{14'h0000, 14'h0062, 14'h0065, 14'h000A,
      14'h2000, 14'h000A, 14'h3455, 14'h0008, 14'h0009, 14'h000B,
      14'h3200, 14'h2ABC};
    for (int i = 0; i < 12; i++) begin
      exec(ops[i]);
      check(nc, (i < 3) ? 1 : 2);
    end
    rd(`REG_ACC, 32'h55);
    rd(`REG_CFG, 32'h5A);
    wr(`REG_MEM_ADDR, 32'h5);
    rd(`REG_DIR, 32'h5A);
    apb(1'b0, `REG_PC, 32'h0);
    check(rv[10:0], 11'h2BC);
    $display("control test done");
  endtask
  task automatic t_sleep();
    exec(14'h0063);
    check(standby, 1'b1);
    rd(`REG_STATUS, 32'h11);
    exec(14'h3E01);
    check(nc, 0);
    wr(`REG_CTRL, 32'h1);
    rd(`REG_ACC, 32'h55);
    check(standby, 1'b0);
    exec(14'h0064);
    rd(`REG_STATUS, 32'h19);
    exec(14'h0001);
    apb(1'b0, `REG_CTRL, 32'h0);
    check(sr, 1'b1);
    $display("standby test done");
  endtask
  // Reset for four cycles, then each scenario in turn
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_arith();
    t_file();
    t_ptr();
    t_ctl();
    t_sleep();
    stop_test();
  end
endmodule
bind enhanced_op_decoder enhanced_op_decoder_asserts u_chk (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .standby, .sw_reset, .busy);
`default_nettype wire
